// [core/sbc_controller.sv]
//
// Purpose: Controller end: drives blank/convert, waits for done, reads result
// Assumes: Same clock as the converter; pins synchronised here
// Notes:   PULSE_MODE 1 idles the line low, 0 idles it high (multiplex)
//
`timescale 1ns/1ns
`include "sbc_regs.svh"
module sbc_controller #(
    parameter bit                      PULSE_MODE = 1'b0,
    parameter logic [`SBC_TIMER_W-1:0] PULSE_CYC  = `SBC_TIMER_W'(`SBC_MIN_PULSE_CYC),
    parameter logic [`SBC_TIMER_W-1:0] OE_CYC     = `SBC_TIMER_W'(`SBC_OE_CYC)
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Link
    sbc_link_if.ctl         link,
    // User request
    input  wire logic       start,
    output logic            ready,
    // User result
    output logic [7:0]      result,
    output logic            result_valid
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic       dn_s1_q;
    logic       dn_s2_q;
    logic [7:0] db_s1_q;
    logic [7:0] db_s2_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dn_s1_q <= 1'b1;
            dn_s2_q <= 1'b1;
            db_s1_q <= 8'hFF;
            db_s2_q <= 8'hFF;
        end else begin
            dn_s1_q <= link.conv_done_n;
            dn_s2_q <= dn_s1_q;
            db_s1_q <= link.data_bus;
            db_s2_q <= db_s1_q;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    sbc_pkg::sbc_ctl_state_t   state_q;
    sbc_pkg::sbc_ctl_state_t   state_d;
    logic [`SBC_TIMER_W-1:0]   timer_q;
    logic [`SBC_TIMER_W-1:0]   timer_d;
    logic                      bc_q;
    logic                      bc_d;
    logic [7:0]                result_q;
    logic [7:0]                result_d;
    logic                      valid_q;
    logic                      valid_d;

    always_comb begin
        state_d  = state_q;
        timer_d  = timer_q;
        bc_d     = bc_q;
        result_d = result_q;
        valid_d  = 1'b0;
        case (state_q)
            sbc_pkg::CTL_IDLE: begin
                // Idle level: low in pulse mode, high (blanked) in multiplex
                bc_d = ~PULSE_MODE;
                if (start) begin
                    state_d = sbc_pkg::CTL_PULSE;
                    timer_d = '0;
                    bc_d    = 1'b1;
                end
            end
            sbc_pkg::CTL_PULSE: begin
                bc_d = 1'b1;
                if (timer_q == PULSE_CYC - `SBC_TIMER_W'(1)) begin
                    // Line has been high long enough to blank and clear
                    bc_d    = 1'b0;
                    state_d = sbc_pkg::CTL_WAIT;
                    timer_d = '0;
                end else begin
                    timer_d = timer_q + `SBC_TIMER_W'(1);
                end
            end
            sbc_pkg::CTL_WAIT: begin
                if (!dn_s2_q) begin
                    state_d = sbc_pkg::CTL_SETTLE;
                    timer_d = '0;
                end
            end
            sbc_pkg::CTL_SETTLE: begin
                if (timer_q == OE_CYC - `SBC_TIMER_W'(1)) begin
                    result_d = db_s2_q;
                    valid_d  = 1'b1;
                    state_d  = sbc_pkg::CTL_IDLE;
                    // Multiplex: release the shared bus right after reading
                    bc_d     = ~PULSE_MODE;
                    timer_d  = '0;
                end else begin
                    timer_d = timer_q + `SBC_TIMER_W'(1);
                end
            end
            default: begin
                state_d = sbc_pkg::CTL_IDLE;
                timer_d = '0;
                bc_d    = ~PULSE_MODE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= sbc_pkg::CTL_IDLE;
            timer_q  <= '0;
            bc_q     <= ~PULSE_MODE;
            result_q <= 8'h00;
            valid_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            timer_q  <= timer_d;
            bc_q     <= bc_d;
            result_q <= result_d;
            valid_q  <= valid_d;
        end
    end

    assign link.blank_convert_n = bc_q;
    assign ready                = (state_q == sbc_pkg::CTL_IDLE);
    assign result               = result_q;
    assign result_valid         = valid_q;

endmodule

// [core/sbc_device.sv]
//
// Purpose: Converter end: blank/convert control, approximation register, outputs
// Assumes: Analog level given as a digital code on ain
// Notes:   Times itself from clk; line passes a two-stage synchroniser
//
`timescale 1ns/1ns
`include "sbc_regs.svh"
module sbc_device #(
    parameter logic [`SBC_TIMER_W-1:0] STEP_CYC  = `SBC_TIMER_W'(`SBC_STEP_CYC),
    parameter logic [`SBC_TIMER_W-1:0] BLANK_CYC = `SBC_TIMER_W'(`SBC_BLANK_CYC),
    parameter logic [`SBC_TIMER_W-1:0] CLEAR_CYC = `SBC_TIMER_W'(`SBC_MIN_PULSE_CYC)
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   resetn,
    // Link
    sbc_link_if.dev     link,
    // Analog stand-in
    input  wire logic [7:0] ain,
    input  wire logic       bipolar,
    // Status
    output logic            converting
);

    // ****************************************************************
    // Line synchroniser
    // ****************************************************************
    logic bc_s1_q;
    logic bc_s2_q;
    logic bc_prev_q;
    logic bc_fall;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bc_s1_q   <= 1'b1;
            bc_s2_q   <= 1'b1;
            bc_prev_q <= 1'b1;
        end else begin
            bc_s1_q   <= link.blank_convert_n;
            bc_s2_q   <= bc_s1_q;
            bc_prev_q <= bc_s2_q;
        end
    end

    assign bc_fall = bc_prev_q & ~bc_s2_q;

    // ****************************************************************
    // Comparator stand-in
    // ****************************************************************
    logic [7:0] target;
    logic [7:0] trial;
    logic       keep_bit;
    logic [7:0] sar_q;
    logic [2:0] bit_q;

    // Bipolar: signed input to offset binary, zero maps to midscale
    assign target   = bipolar ? (ain ^ `SBC_BIPOLAR_ZERO) : ain;
    assign trial    = sar_q | (8'h01 << bit_q);
    assign keep_bit = (trial <= target);

    // ****************************************************************
    // Control state
    // ****************************************************************
    sbc_pkg::sbc_dev_state_t         state_q;
    sbc_pkg::sbc_dev_state_t         state_d;
    logic [`SBC_TIMER_W-1:0]         timer_q;
    logic [`SBC_TIMER_W-1:0]         timer_d;
    logic [7:0]                      sar_d;
    logic [2:0]                      bit_d;
    logic                            done_n_q;
    logic                            done_n_d;
    logic                            oe_q;
    logic                            oe_d;
    logic [7:0]                      data_q;
    logic [7:0]                      data_d;

    always_comb begin
        state_d  = state_q;
        timer_d  = timer_q;
        sar_d    = sar_q;
        bit_d    = bit_q;
        done_n_d = done_n_q;
        oe_d     = oe_q;
        data_d   = data_q;
        case (state_q)
            sbc_pkg::DEV_STANDBY: begin
                done_n_d = 1'b1;
                oe_d     = 1'b0;
                if (bc_fall) begin
                    // Outputs left as they are on the start edge
                    state_d = sbc_pkg::DEV_CONVERT;
                    timer_d = '0;
                    sar_d   = 8'h00;
                    bit_d   = 3'h7;
                end
            end
            sbc_pkg::DEV_CONVERT: begin
                if (bc_s2_q) begin
                    // Halt; done and data untouched
                    state_d = sbc_pkg::DEV_HALT;
                    timer_d = '0;
                end else if (timer_q == STEP_CYC - `SBC_TIMER_W'(1)) begin
                    timer_d = '0;
                    sar_d   = keep_bit ? trial : sar_q;
                    if (bit_q == 3'h0) begin
                        state_d  = sbc_pkg::DEV_DONE;
                        done_n_d = 1'b0;
                        data_d   = keep_bit ? trial : sar_q;
                    end else begin
                        bit_d = bit_q - 3'h1;
                    end
                end else begin
                    timer_d = timer_q + `SBC_TIMER_W'(1);
                end
            end
            sbc_pkg::DEV_HALT: begin
                if (timer_q != CLEAR_CYC) begin
                    timer_d = timer_q + `SBC_TIMER_W'(1);
                end
                if (!bc_s2_q) begin
                    state_d = sbc_pkg::DEV_CONVERT;
                    if (timer_q == CLEAR_CYC) begin
                        // Long pulse cleared the register: start over
                        sar_d   = 8'h00;
                        bit_d   = 3'h7;
                    end
                    timer_d = '0;
                end
            end
            sbc_pkg::DEV_DONE: begin
                // Data driven one cycle after done falls
                oe_d = 1'b1;
                if (bc_s2_q) begin
                    state_d = sbc_pkg::DEV_BLANKING;
                    timer_d = '0;
                end
            end
            sbc_pkg::DEV_BLANKING: begin
                oe_d = 1'b1;
                if (!bc_s2_q) begin
                    // Early fall: fresh conversion, outputs unchanged
                    state_d = sbc_pkg::DEV_CONVERT;
                    timer_d = '0;
                    sar_d   = 8'h00;
                    bit_d   = 3'h7;
                end else if (timer_q == BLANK_CYC - `SBC_TIMER_W'(1)) begin
                    state_d  = sbc_pkg::DEV_STANDBY;
                    done_n_d = 1'b1;
                    oe_d     = 1'b0;
                    timer_d  = '0;
                end else begin
                    timer_d = timer_q + `SBC_TIMER_W'(1);
                end
            end
            default: begin
                state_d  = sbc_pkg::DEV_STANDBY;
                timer_d  = '0;
                done_n_d = 1'b1;
                oe_d     = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= sbc_pkg::DEV_STANDBY;
            timer_q  <= '0;
            sar_q    <= 8'h00;
            bit_q    <= 3'h7;
            done_n_q <= 1'b1;
            oe_q     <= 1'b0;
            data_q   <= 8'h00;
        end else begin
            state_q  <= state_d;
            timer_q  <= timer_d;
            sar_q    <= sar_d;
            bit_q    <= bit_d;
            done_n_q <= done_n_d;
            oe_q     <= oe_d;
            data_q   <= data_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.conv_done_n = done_n_q;
    assign link.data_oe     = oe_q;
    assign link.data_o      = data_q;
    assign converting       = (state_q == sbc_pkg::DEV_CONVERT);

endmodule

// [core/sbc_link_if.sv]
//
// Purpose: Pin level link between converter and its controller
// Assumes: One clock for both ends
// Notes:   Data bus reads high when undriven (pull-up model)
//
`timescale 1ns/1ns
interface sbc_link_if;

    logic       blank_convert_n;
    logic       conv_done_n;
    logic [7:0] data_o;
    logic       data_oe;
    logic [7:0] data_bus;

    assign data_bus = data_oe ? data_o : 8'hFF;

    modport dev (
        input  blank_convert_n,
        output conv_done_n,
        output data_o,
        output data_oe
    );

    modport ctl (
        output blank_convert_n,
        input  conv_done_n,
        input  data_bus
    );

endinterface

// [core/sbc_pkg.sv]
//
// Purpose: Types shared by both ends of the converter link
// Assumes: Constants live in sbc_regs.svh
// Notes:   Gray codes along the usual path
//
package sbc_pkg;

    typedef enum logic [2:0] {
        DEV_STANDBY  = 3'h0,
        DEV_CONVERT  = 3'h1,
        DEV_DONE     = 3'h3,
        DEV_BLANKING = 3'h2,
        DEV_HALT     = 3'h5
    } sbc_dev_state_t;

    typedef enum logic [2:0] {
        CTL_IDLE   = 3'h0,
        CTL_PULSE  = 3'h1,
        CTL_WAIT   = 3'h3,
        CTL_SETTLE = 3'h2
    } sbc_ctl_state_t;

endpackage

// [core/sbc_regs.svh]
//
// Purpose: Timing constants and codes for the blank/convert converter link
// Assumes: 50 MHz clock, 20 ns period
// Notes:   Timing counts are in clock cycles
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SBC_CLK_PERIOD_NS  20
`define SBC_CONV_TIME_NS   25000
`define SBC_CONV_CYC       (`SBC_CONV_TIME_NS / `SBC_CLK_PERIOD_NS)
`define SBC_RES_BITS       8
`define SBC_STEP_CYC       (`SBC_CONV_CYC / `SBC_RES_BITS)
`define SBC_OE_MAX_NS      500
`define SBC_OE_CYC         (`SBC_OE_MAX_NS / `SBC_CLK_PERIOD_NS)
`define SBC_BLANK_NS       1500
`define SBC_BLANK_CYC      (`SBC_BLANK_NS / `SBC_CLK_PERIOD_NS)
`define SBC_MIN_PULSE_NS   2000
`define SBC_MIN_PULSE_CYC  ((`SBC_MIN_PULSE_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_OVERLAP_NS     15000
`define SBC_OVERLAP_CYC    (`SBC_OVERLAP_NS / `SBC_CLK_PERIOD_NS)

// ****************************************************************
// Codes
// ****************************************************************
`define SBC_BIPOLAR_ZERO   8'h80
`define SBC_TIMER_W        12

`endif

// [dv/sbc_link_monitor.sv]
// Purpose: Protocol checks on the converter link
// Assumes: Device built with STEP_CYC 4, BLANK_CYC 5
// Notes:   Windows below are sized for those values
`timescale 1ns/1ns
module sbc_link_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Link
    input wire logic       blank_convert_n,
    input wire logic       conv_done_n,
    input wire logic [7:0] data_o,
    input wire logic       data_oe,
    input wire logic [7:0] data_bus
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Consecutive cycles with the line high, saturating
    logic [3:0] hi_cnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt_q <= 4'h0;
        end else if (!blank_convert_n) begin
            hi_cnt_q <= 4'h0;
        end else if (hi_cnt_q != 4'hF) begin
            hi_cnt_q <= hi_cnt_q + 4'h1;
        end
    end

    // ****
    // Assertions
    // ****
    standby_blank_a: assert property (
        blank_convert_n && hi_cnt_q >= 4'h9 |-> conv_done_n && !data_oe) else $error("not blanked");
    start_quiet_a: assert property (
        $fell(blank_convert_n) |-> (conv_done_n && !data_oe) [*8]) else $error("moved at start");
    conv_time_a: assert property (
        $fell(blank_convert_n) |-> ##[30:40] $fell(conv_done_n)) else $error("done late");
    done_line_low_a: assert property (
        $fell(conv_done_n) |-> !blank_convert_n) else $error("done while blanked");
    oe_lag_a: assert property (
        $fell(conv_done_n) |-> !data_oe ##1 data_oe) else $error("outputs not enabled");
    blank_delay_a: assert property ($rose(blank_convert_n) && !conv_done_n |->
        (!conv_done_n && data_oe) [*5] ##[1:6] (conv_done_n && !data_oe)) else $error("blank time");
    done_oe_pair_a: assert property (
        $rose(conv_done_n) || $fell(data_oe) |-> conv_done_n && !data_oe) else $error("unpaired");
    data_hold_a: assert property (
        data_oe [*2] |-> $stable(data_o)) else $error("data moved while driven");

    cover property ($fell(conv_done_n));
    cover property ($rose(blank_convert_n) && !conv_done_n);
    cover property (data_oe && data_bus == 8'h80);
endmodule

// [dv/test_sar_adc_blank_convert_ctrl.sv]
// Purpose: Self-checking bench for both link ends
// Assumes: Shortened device and controller timings
// Notes:   Second device driven directly for halt cases
`timescale 1ns/1ns
module test_sar_adc_blank_convert_ctrl;
    logic       clk;
    logic       resetn;
    logic       start;
    logic       ready;
    logic       result_valid;
    logic [7:0] result;
    logic [7:0] ain;
    logic       bipolar;
    logic [7:0] ain_b;
    logic       bip_b;
    logic       conv_b;
    localparam logic [11:0] T_STEP  = 12'h004;
    localparam logic [11:0] T_BLANK = 12'h005;
    localparam logic [11:0] T_CLEAR = 12'h008;
    localparam logic [11:0] T_PULSE = 12'h00A;
    localparam logic [11:0] T_OE    = 12'h004;
    int         failures;
    int         samples_checked;
    logic [7:0] vals [8] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01, 8'h00, 8'h80, 8'h7F};
    logic [7:0] bips     = 8'hE0;

    sbc_link_if link_a ();
    sbc_link_if link_b ();
    sbc_device #(.STEP_CYC(T_STEP), .BLANK_CYC(T_BLANK), .CLEAR_CYC(T_CLEAR)) sbc_device_i (
        .clk(clk), .resetn(resetn), .link(link_a.dev), .ain(ain), .bipolar(bipolar),
        .converting());
    sbc_device #(.STEP_CYC(T_STEP), .BLANK_CYC(T_BLANK), .CLEAR_CYC(T_CLEAR)) sbc_device_b_i (
        .clk(clk), .resetn(resetn), .link(link_b.dev), .ain(ain_b), .bipolar(bip_b),
        .converting(conv_b));
    sbc_controller #(.PULSE_CYC(T_PULSE), .OE_CYC(T_OE)) sbc_controller_i (
        .clk(clk), .resetn(resetn), .link(link_a.ctl), .start(start), .ready(ready),
        .result(result), .result_valid(result_valid));
    sbc_link_monitor sbc_link_monitor_i (
        .clk(clk), .resetn(resetn), .blank_convert_n(link_a.blank_convert_n),
        .conv_done_n(link_a.conv_done_n), .data_o(link_a.data_o), .data_oe(link_a.data_oe),
        .data_bus(link_a.data_bus));

    // ****
    // Helpers
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic probe(input int sel);
        case (sel)
            0: return ready;
            1: return result_valid;
            default: return link_b.conv_done_n;
        endcase
    endfunction

    task automatic wait_for(input int sel, input logic lvl);
        int n;
        n = 0;
        while (probe(sel) !== lvl && n < 300) begin
            step(1);
            n++;
        end
        if (probe(sel) !== lvl) begin
            failures++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            final_report();
        end
    endtask

    task automatic convert(input logic [7:0] val, input logic bip, input logic [7:0] exp);
        ain = val;
        bipolar = bip;
        wait_for(0, 1'b1);
        start = 1'b1;
        step(1);
        start = 1'b0;
        wait_for(1, 1'b1);
        check(result, exp);
    endtask

    // Lower the direct line, wait for done, read the bus
    task automatic read_b(input logic [7:0] exp);
        link_b.blank_convert_n = 1'b0;
        wait_for(2, 1'b0);
        step(2);
        check(link_b.data_bus, exp);
    endtask

    task automatic check_blank_b();
        check({7'h00, link_b.conv_done_n}, 8'h01);
        check(link_b.data_bus, 8'hFF);
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        start = 1'b0;
        ain = 8'h00;
        bipolar = 1'b0;
        ain_b = 8'h96;
        bip_b = 1'b0;
        link_b.blank_convert_n = 1'b1;
        failures = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        #2;
        resetn = 1'b1;
        step(1);
        check_blank_b();
        check(link_a.data_bus, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            convert(vals[i], bips[i], vals[i] ^ {bips[i], 7'h00});
        end
        step(12);
        check(link_a.data_bus, 8'hFF);
        $display("test controller conversions ended");
        link_b.blank_convert_n = 1'b0;
        step(10);
        check_blank_b();
        check({7'h00, conv_b}, 8'h01);
        read_b(8'h96);
        link_b.blank_convert_n = 1'b1;
        step(3);
        check(link_b.data_bus, 8'h96);
        step(10);
        check_blank_b();
        ain_b = 8'h3C;
        link_b.blank_convert_n = 1'b0;
        step(10);
        link_b.blank_convert_n = 1'b1;
        step(4);
        check_blank_b();
        read_b(8'h3C);
        link_b.blank_convert_n = 1'b1;
        step(12);
        link_b.blank_convert_n = 1'b0;
        step(12);
        link_b.blank_convert_n = 1'b1;
        ain_b = 8'hC3;
        step(20);
        check_blank_b();
        read_b(8'hC3);
        $display("test direct device halts ended");
        final_report();
    end
endmodule
